// >>> include/ltco_pkg.sv
// package: register map, field layout, reset values and limits for the lane 0 override bank
package ltco_pkg;

   // printed offsets are not all multiples of four: they are register indices
   localparam logic [7:0]  IDX_TRAIN_CTRL    = 8'hd0;
   localparam logic [7:0]  IDX_NEW_WORD_CTRL = 8'hd2;
   localparam logic [7:0]  IDX_PARTNER_COEF  = 8'hd4;
   localparam logic [7:0]  IDX_TX_LIMIT_OVR  = 8'hd6;
   localparam logic [11:0] ADDR_TRAIN_CTRL    = {2'b00, IDX_TRAIN_CTRL, 2'b00};
   localparam logic [11:0] ADDR_NEW_WORD_CTRL = {2'b00, IDX_NEW_WORD_CTRL, 2'b00};
   localparam logic [11:0] ADDR_PARTNER_COEF  = {2'b00, IDX_PARTNER_COEF, 2'b00};
   localparam logic [11:0] ADDR_TX_LIMIT_OVR  = {2'b00, IDX_TX_LIMIT_OVR, 2'b00};

   // training control fields
   localparam int TRAIN_EN_BIT     = 0;
   localparam int COEF_OVR_EN_BIT  = 17;
   localparam int NEW_WORD_BIT     = 8;

   // partner coefficient request fields
   localparam int COEF_PLUS_LSB  = 4;
   localparam int COEF_ZERO_LSB  = 2;
   localparam int COEF_MINUS_LSB = 0;
   localparam int PCOEF_RX_LSB   = 16;

   // two-bit coefficient request codes
   typedef enum logic [1:0] {
      LTCO_COEF_HOLD     = 2'b00,
      LTCO_COEF_INC      = 2'b01,
      LTCO_COEF_DEC      = 2'b10,
      LTCO_COEF_RESERVED = 2'b11
   } ltco_coef_e;

   // tx limit override fields
   localparam int MAX_SWING_LSB  = 0;
   localparam int MAX_SWING_EN   = 5;
   localparam int MIN_SWING_LSB  = 8;
   localparam int MIN_SWING_EN   = 13;
   localparam int POST_LSB       = 16;
   localparam int POST_EN        = 22;

   // reset values: simulation build versus compiled build
   localparam logic [4:0] MAX_SWING_RST_SIM = 5'h1c;
   localparam logic [4:0] MIN_SWING_RST_SIM = 5'h19;
   localparam logic [5:0] POST_RST_SIM      = 6'h06;
   localparam logic       OVR_EN_RST_SIM    = 1'b1;
   localparam logic [4:0] MAX_SWING_RST_HW  = 5'h00;
   localparam logic [4:0] MIN_SWING_RST_HW  = 5'h00;
   localparam logic [5:0] POST_RST_HW       = 6'h00;
   localparam logic       OVR_EN_RST_HW     = 1'b0;
   localparam logic       TRAIN_EN_RST      = 1'b1;

   // compile-time limits, plain defaults
   localparam logic [4:0] MAX_SWING_LIMIT_PARAM  = 5'h1e;
   localparam logic [4:0] MIN_SWING_LIMIT_PARAM  = 5'h09;
   localparam logic [5:0] POST_CURSOR_LIMIT_PARAM = 6'h19;
   localparam logic [4:0] PRESET_MAIN_TAP_PARAM  = 5'h1e;

   localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

endpackage : ltco_pkg

// >>> include/ltco_lim_if.sv
// interface: transmit limit override values and their enables handed from the register bank to the selector
`timescale 1ns/1ps
interface ltco_lim_if;
   logic [4:0] max_swing_override;
   logic       max_swing_override_en;
   logic [4:0] min_swing_override;
   logic       min_swing_override_en;
   logic [5:0] post_cursor_override;
   logic       post_cursor_override_en;
   modport regs (output max_swing_override, max_swing_override_en, min_swing_override,
                 min_swing_override_en, post_cursor_override, post_cursor_override_en);
   modport sel  (input max_swing_override, max_swing_override_en, min_swing_override,
                 min_swing_override_en, post_cursor_override, post_cursor_override_en);
endinterface : ltco_lim_if

// >>> core/ltco_limit_sel.sv
// module: picks override or compile-time value for each transmit limit
`timescale 1ns/1ps
module ltco_limit_sel
   import ltco_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       sys_rst,
   ltco_lim_if.sel         lim,
   output logic      [4:0] max_swing_limit_q,
   output logic      [4:0] preset_main_tap_q,
   output logic      [4:0] min_swing_limit_q,
   output logic      [5:0] post_cursor_limit_q
);

   // registered so the training engine sees a clean value, one cycle after a write
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         max_swing_limit_q   <= MAX_SWING_LIMIT_PARAM;
         preset_main_tap_q   <= PRESET_MAIN_TAP_PARAM;
         min_swing_limit_q   <= MIN_SWING_LIMIT_PARAM;
         post_cursor_limit_q <= POST_CURSOR_LIMIT_PARAM;
      end else begin
         // disabled override falls back to the built-in value
         max_swing_limit_q   <= lim.max_swing_override_en ? lim.max_swing_override
                                                          : MAX_SWING_LIMIT_PARAM;
         // max override also replaces the preset main value
         preset_main_tap_q   <= lim.max_swing_override_en ? lim.max_swing_override
                                                          : PRESET_MAIN_TAP_PARAM;
         min_swing_limit_q   <= lim.min_swing_override_en ? lim.min_swing_override
                                                          : MIN_SWING_LIMIT_PARAM;
         post_cursor_limit_q <= lim.post_cursor_override_en ? lim.post_cursor_override
                                                            : POST_CURSOR_LIMIT_PARAM;
      end
   end

endmodule : ltco_limit_sel

// >>> core/ltco_regs.sv
// module: lane 0 training coefficient and tx limit override registers on apb
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
// Overview of operation
// - partner coef writable only with training disabled
// - bits 5:4 plus-one request, 11 reserved
// - bits 3:2 main, 1:0 minus-one, same code
// - max swing override field 4:0, lane local
// - bit 5 enables max swing override
// - min swing override field 12:8
// - bit 13 enables min swing override
// - post-cursor override field 21:16
// - bit 22 enables post-cursor override
module ltco_regs
   import ltco_pkg::*;
#(
   parameter bit SIM_BUILD = 1'b0
)
(
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic  [5:0] rx_partner_coef,
   input  wire logic        rx_partner_coef_vld,
   output logic             train_en,
   output logic             coef_ovr_en,
   output logic             coef_new_word,
   output logic       [5:0] partner_coef_request,
   output logic       [4:0] max_swing_limit,
   output logic       [4:0] preset_main_tap,
   output logic       [4:0] min_swing_limit,
   output logic       [5:0] post_cursor_limit
);

   localparam logic [4:0] MAX_RST = SIM_BUILD ? MAX_SWING_RST_SIM : MAX_SWING_RST_HW;
   localparam logic [4:0] MIN_RST = SIM_BUILD ? MIN_SWING_RST_SIM : MIN_SWING_RST_HW;
   localparam logic [5:0] PST_RST = SIM_BUILD ? POST_RST_SIM : POST_RST_HW;
   localparam logic       EN_RST  = SIM_BUILD ? OVR_EN_RST_SIM : OVR_EN_RST_HW;

   logic       train_en_q;
   logic       coef_ovr_en_q;
   logic       new_word_q;
   logic [5:0] pcoef_q;
   logic [5:0] pcoef_rx_q;
   logic [4:0] max_ovr_q;
   logic       max_en_q;
   logic [4:0] min_ovr_q;
   logic       min_en_q;
   logic [5:0] post_ovr_q;
   logic       post_en_q;
   logic       wr_acc;
   logic       rd_acc;
   logic       hit;
   logic [31:0] rdata_d;
   logic [31:0] prdata_q;
   logic       pslverr_q;

   ltco_lim_if lim_bus ();

   // reserved code 11 is written back as hold so the engine never sees it
   function automatic logic [1:0] coef_fix(input logic [1:0] code);
      coef_fix = (code == LTCO_COEF_RESERVED) ? LTCO_COEF_HOLD : code;
   endfunction : coef_fix

   function automatic logic addr_hit(input logic [11:0] a);
      addr_hit = (a == ADDR_TRAIN_CTRL) || (a == ADDR_NEW_WORD_CTRL) ||
                 (a == ADDR_PARTNER_COEF) || (a == ADDR_TX_LIMIT_OVR);
   endfunction : addr_hit

   // zero-wait slave: the access phase always completes in its first cycle
   assign pready  = 1'b1;
   assign wr_acc  = psel & penable & pwrite;
   assign rd_acc  = psel & penable & ~pwrite;
   assign hit     = addr_hit(paddr);

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         train_en_q    <= TRAIN_EN_RST;
         coef_ovr_en_q <= 1'b0;
      end else if (wr_acc && paddr == ADDR_TRAIN_CTRL) begin
         train_en_q    <= pwdata[TRAIN_EN_BIT];
         coef_ovr_en_q <= pwdata[COEF_OVR_EN_BIT];
      end
   end

   // new-word flag is a one-cycle pulse; only meaningful with override on
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         new_word_q <= 1'b0;
      end else begin
         new_word_q <= wr_acc && (paddr == ADDR_NEW_WORD_CTRL) && pwdata[NEW_WORD_BIT]
                       && coef_ovr_en_q;
      end
   end

   // software copy of the request word; writes refused while training runs
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         pcoef_q <= 6'h00;
      end else if (wr_acc && paddr == ADDR_PARTNER_COEF && !train_en_q) begin
         pcoef_q <= {coef_fix(pwdata[COEF_PLUS_LSB +: 2]),
                     coef_fix(pwdata[COEF_ZERO_LSB +: 2]),
                     coef_fix(pwdata[COEF_MINUS_LSB +: 2])};
      end
   end

   // last word received from the partner, shown read-only
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         pcoef_rx_q <= 6'h00;
      end else if (rx_partner_coef_vld) begin
         pcoef_rx_q <= rx_partner_coef;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         max_ovr_q  <= MAX_RST;
         max_en_q   <= EN_RST;
         min_ovr_q  <= MIN_RST;
         min_en_q   <= EN_RST;
         post_ovr_q <= PST_RST;
         post_en_q  <= EN_RST;
      end else if (wr_acc && paddr == ADDR_TX_LIMIT_OVR) begin
         max_ovr_q  <= pwdata[MAX_SWING_LSB +: 5];
         max_en_q   <= pwdata[MAX_SWING_EN];
         min_ovr_q  <= pwdata[MIN_SWING_LSB +: 5];
         min_en_q   <= pwdata[MIN_SWING_EN];
         post_ovr_q <= pwdata[POST_LSB +: 6];
         post_en_q  <= pwdata[POST_EN];
      end
   end

   always_comb begin
      rdata_d = RDATA_ZERO;
      if (paddr == ADDR_TRAIN_CTRL) begin
         rdata_d[TRAIN_EN_BIT]    = train_en_q;
         rdata_d[COEF_OVR_EN_BIT] = coef_ovr_en_q;
      end else if (paddr == ADDR_PARTNER_COEF) begin
         rdata_d[5:0]                  = pcoef_q;
         rdata_d[PCOEF_RX_LSB +: 6]    = pcoef_rx_q;
      end else if (paddr == ADDR_TX_LIMIT_OVR) begin
         rdata_d[MAX_SWING_LSB +: 5] = max_ovr_q;
         rdata_d[MAX_SWING_EN]       = max_en_q;
         rdata_d[MIN_SWING_LSB +: 5] = min_ovr_q;
         rdata_d[MIN_SWING_EN]       = min_en_q;
         rdata_d[POST_LSB +: 6]      = post_ovr_q;
         rdata_d[POST_EN]            = post_en_q;
      end
   end

   // read data registered during setup so it is valid across the access phase
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         prdata_q <= RDATA_ZERO;
      end else if (psel && !penable && !pwrite) begin
         prdata_q <= rdata_d;
      end
   end

   assign prdata  = rd_acc ? prdata_q : RDATA_ZERO;
   assign pslverr = psel & penable & ~hit;

   assign lim_bus.max_swing_override      = max_ovr_q;
   assign lim_bus.max_swing_override_en   = max_en_q;
   assign lim_bus.min_swing_override      = min_ovr_q;
   assign lim_bus.min_swing_override_en   = min_en_q;
   assign lim_bus.post_cursor_override    = post_ovr_q;
   assign lim_bus.post_cursor_override_en = post_en_q;

   ltco_limit_sel u_sel (
      .mclk                (mclk),
      .sys_rst             (sys_rst),
      .lim                 (lim_bus),
      .max_swing_limit_q   (max_swing_limit),
      .preset_main_tap_q   (preset_main_tap),
      .min_swing_limit_q   (min_swing_limit),
      .post_cursor_limit_q (post_cursor_limit)
   );

   assign train_en             = train_en_q;
   assign coef_ovr_en          = coef_ovr_en_q;
   assign coef_new_word        = new_word_q;
   assign partner_coef_request = pcoef_q;

endmodule : ltco_regs

// >>> tb/ltco_regs_asserts.sv
// checker: port assertions for the lane 0 override bank
`timescale 1ns/1ps
module ltco_regs_asserts
   import ltco_pkg::*;
(
   input wire logic        mclk,
   input wire logic        sys_rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        train_en,
   input wire logic        coef_ovr_en,
   input wire logic        coef_new_word,
   input wire logic [5:0]  partner_coef_request,
   input wire logic [4:0]  max_swing_limit,
   input wire logic [4:0]  preset_main_tap,
   input wire logic [4:0]  min_swing_limit,
   input wire logic [5:0]  post_cursor_limit
);
   logic wr;
   logic tx_wr;
   logic cf_wr;
   assign wr    = psel & penable & pwrite & pready;
   assign tx_wr = wr & (paddr == ADDR_TX_LIMIT_OVR);
   assign cf_wr = wr & (paddr == ADDR_PARTNER_COEF) & ~train_en;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   a_coef_locked: assert property (
      wr && paddr == ADDR_PARTNER_COEF && train_en |=> $stable(partner_coef_request))
      else $error("coef word changed while training on");
   a_coef_store: assert property (
      cf_wr && pwdata[5:4] != 2'b11 && pwdata[3:2] != 2'b11 && pwdata[1:0] != 2'b11
      |=> partner_coef_request == $past(pwdata[5:0]))
      else $error("coef word not stored");
   a_coef_rsvd: assert property (
      cf_wr && pwdata[5:4] == 2'b11 |=> partner_coef_request[5:4] == 2'b00)
      else $error("reserved code kept");
   a_new_pulse: assert property (
      wr && paddr == ADDR_NEW_WORD_CTRL && pwdata[8] && coef_ovr_en
      |=> coef_new_word ##1 !coef_new_word)
      else $error("new word pulse wrong");
   a_new_cause: assert property (
      $rose(coef_new_word) |-> $past(wr && paddr == ADDR_NEW_WORD_CTRL && coef_ovr_en))
      else $error("new word pulse without cause");
   // limits lag the register by one edge, hence two cycles back
   a_max_sel: assert property (
      tx_wr |=> ##1 max_swing_limit ==
      ($past(pwdata[5], 2) ? $past(pwdata[4:0], 2) : MAX_SWING_LIMIT_PARAM))
      else $error("max swing limit wrong");
   a_preset_sel: assert property (
      tx_wr |=> ##1 preset_main_tap ==
      ($past(pwdata[5], 2) ? $past(pwdata[4:0], 2) : PRESET_MAIN_TAP_PARAM))
      else $error("preset main tap wrong");
   a_min_sel: assert property (
      tx_wr |=> ##1 min_swing_limit ==
      ($past(pwdata[13], 2) ? $past(pwdata[12:8], 2) : MIN_SWING_LIMIT_PARAM))
      else $error("min swing limit wrong");
   a_post_sel: assert property (
      tx_wr |=> ##1 post_cursor_limit ==
      ($past(pwdata[22], 2) ? $past(pwdata[21:16], 2) : POST_CURSOR_LIMIT_PARAM))
      else $error("post cursor limit wrong");
   c_new: cover property (coef_new_word);
   c_lock: cover property (wr && paddr == ADDR_PARTNER_COEF && train_en);
   c_err: cover property (pslverr);
endmodule : ltco_regs_asserts
bind ltco_regs ltco_regs_asserts i_chk (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .pslverr(pslverr), .train_en(train_en), .coef_ovr_en(coef_ovr_en),
   .coef_new_word(coef_new_word), .partner_coef_request(partner_coef_request),
   .max_swing_limit(max_swing_limit), .preset_main_tap(preset_main_tap),
   .min_swing_limit(min_swing_limit), .post_cursor_limit(post_cursor_limit));

// >>> tb/testbench.sv
// testbench: apb scoreboard test of the lane 0 override bank
`timescale 1ns/1ps
module testbench
   import ltco_pkg::*;
;
   logic        mclk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, rx_vld = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, v;
   logic [5:0]  rx_coef = 6'h00, pcoef, post_lim, sw, hw_post;
   logic [4:0]  max_lim, pre_lim, min_lim, hw_max, hw_pre, hw_min;
   localparam logic [20:0] HW_LIMS = {MAX_SWING_LIMIT_PARAM, PRESET_MAIN_TAP_PARAM,
                                      MIN_SWING_LIMIT_PARAM, POST_CURSOR_LIMIT_PARAM};
   logic        pready, pslverr, train_en, coef_ovr_en, coef_new_word;
   logic [32:0] exp_q[$];
   int          bad_count = 0, checked = 0, cyc = 0, pulses = 0;
   always #2 mclk = ~mclk;
   // simulation build: non-zero override reset values make reset checks meaningful
   ltco_regs #(.SIM_BUILD(1'b1)) i_dut (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rx_partner_coef(rx_coef),
      .rx_partner_coef_vld(rx_vld), .train_en(train_en), .coef_ovr_en(coef_ovr_en),
      .coef_new_word(coef_new_word), .partner_coef_request(pcoef),
      .max_swing_limit(max_lim), .preset_main_tap(pre_lim), .min_swing_limit(min_lim),
      .post_cursor_limit(post_lim));
   // compiled build: overrides come out of reset disabled, so built-in limits must show
   ltco_regs #(.SIM_BUILD(1'b0)) i_dut_hw (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(),
      .pready(), .pslverr(), .rx_partner_coef(rx_coef),
      .rx_partner_coef_vld(rx_vld), .train_en(), .coef_ovr_en(),
      .coef_new_word(), .partner_coef_request(),
      .max_swing_limit(hw_max), .preset_main_tap(hw_pre), .min_swing_limit(hw_min),
      .post_cursor_limit(hw_post));
   task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task automatic conclude;
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : conclude
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      // no limit of its own: only the bench timeout ends a stuck wait
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask : apb
   task automatic rd(input logic [11:0] a, input logic [32:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0000_0000);
   endtask : rd
   // one extra edge: limit outputs trail the register write by one cycle
   task automatic lim(input logic [31:0] t);
      @(posedge mclk);
      cmp({12'h000, max_lim, pre_lim, min_lim, post_lim}, {12'h000,
          t[5] ? t[4:0] : MAX_SWING_LIMIT_PARAM, t[5] ? t[4:0] : PRESET_MAIN_TAP_PARAM,
          t[13] ? t[12:8] : MIN_SWING_LIMIT_PARAM, t[22] ? t[21:16] : POST_CURSOR_LIMIT_PARAM});
   endtask : lim
   function automatic logic [5:0] san(input logic [5:0] c);
      for (int i = 0; i < 6; i += 2) if (c[i+:2] == 2'b11) c[i+:2] = 2'b00;
      return c;
   endfunction : san
   always @(posedge mclk) begin
      if (pready === 1'b1 && psel && penable && !pwrite && exp_q.size() > 0)
         cmp({pslverr, prdata}, exp_q.pop_front());
      if (coef_new_word === 1'b1) pulses++;
      cyc++;
      if (cyc == 5000) begin
         bad_count++;
         conclude;
      end
   end
   initial begin
      v = $urandom(57659);
      repeat (20) @(posedge mclk);
      sys_rst <= 1'b0;
      rx_coef <= 6'($urandom);
      rx_vld <= 1'b1;
      @(posedge mclk);
      rx_vld <= 1'b0;
      lim(32'h0046_393c);
      cmp({12'h000, hw_max, hw_pre, hw_min, hw_post}, {12'h000, HW_LIMS});
      rd(ADDR_TX_LIMIT_OVR, {1'b0, 32'h0046_393c});
      rd(ADDR_TRAIN_CTRL, {1'b0, 32'h0000_0001});
      apb(1'b1, ADDR_PARTNER_COEF, 32'h0000_0019);
      rd(ADDR_PARTNER_COEF, {1'b0, 10'h000, rx_coef, 16'h0000});
      apb(1'b1, ADDR_TRAIN_CTRL, 32'h0002_0000);
      cmp({31'h0000_0000, train_en, coef_ovr_en}, 33'h0_0000_0001);
      rd(ADDR_TRAIN_CTRL, {1'b0, 32'h0002_0000});
      for (int i = 0; i < 8; i++) begin
         sw = (i < 4) ? {3{2'(i)}} : 6'($urandom);
         apb(1'b1, ADDR_PARTNER_COEF, {26'h000_0000, sw});
         rd(ADDR_PARTNER_COEF, {1'b0, 10'h000, rx_coef, 10'h000, san(sw)});
         cmp({27'h000_0000, pcoef}, {27'h000_0000, san(sw)});
      end
      apb(1'b1, ADDR_NEW_WORD_CTRL, 32'h0000_0100);
      // one more edge so the pulse counter has surely run at the edge the pulse stood
      @(posedge mclk);
      cmp(33'(pulses), 33'h0_0000_0001);
      apb(1'b1, ADDR_TRAIN_CTRL, 32'h0000_0000);
      apb(1'b1, ADDR_NEW_WORD_CTRL, 32'h0000_0100);
      @(posedge mclk);
      cmp(33'(pulses), 33'h0_0000_0001);
      rd(ADDR_NEW_WORD_CTRL, {1'b0, 32'h0000_0000});
      for (int i = 0; i < 8; i++) begin
         v = $urandom;
         v[5] = i[0];
         v[13] = i[1];
         v[22] = i[2];
         apb(1'b1, ADDR_TX_LIMIT_OVR, v);
         lim(v);
         rd(ADDR_TX_LIMIT_OVR, {1'b0, v & 32'h007f_3f3f});
      end
      rd(12'h35c, {1'b1, 32'h0000_0000});
      sys_rst <= 1'b1;
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      lim(32'h0046_393c);
      cmp({31'h0000_0000, train_en, coef_ovr_en}, 33'h0_0000_0002);
      rd(ADDR_TRAIN_CTRL, {1'b0, 32'h0000_0001});
      conclude;
   end
endmodule : testbench
